// ---- core/line_decode_if.sv ----
/*
 interface carrying one line decoder's results to the trigger logic.
 assumes one producer (line decoder) and one consumer (top) on ref_clk.
*/
`timescale 1ns/1ps
interface line_decode_if;
   logic start_p;
   logic stop_p;
   logic word_valid;
   logic [7:0] word;
   logic err;
   logic busy;
   logic idle_fault;
   modport producer (output start_p, stop_p, word_valid, word, err, busy, idle_fault);
   modport consumer (input start_p, stop_p, word_valid, word, err, busy, idle_fault);
endinterface

// ---- core/line_decoder.sv ----
/*
 decodes asynchronous characters on one synchronised line.
 assumes the line idles high and bit_cycles is at least four.
*/
`timescale 1ns/1ps
`include "serial_trig_consts.svh"
module line_decoder
   import serial_trig_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic line,
   input wire logic [19:0] bit_cycles,
   input wire logic [1:0] len_sel,
   input wire serial_trig_pkg::parity_t parity,
   input wire serial_trig_pkg::stop_t stop_bits,
   line_decode_if.producer res
);
   dec_state_t st_ff, nxt_st;
   logic [19:0] cnt_ff, nxt_cnt;
   logic [2:0] idx_ff, nxt_idx;
   logic [7:0] word_ff, nxt_word;
   logic perr_ff, nxt_perr, prev_ff;
   logic start_ff, nxt_start, stop_ff, nxt_stop, valid_ff, nxt_valid, err_ff, nxt_err, fault_ff, nxt_fault;
   logic [19:0] half;
   logic [2:0] last_idx;

   always_comb begin
      half = {1'b0, bit_cycles[19:1]};
      last_idx = `MIN_DATA_BITS + {1'b0, len_sel};
      nxt_st = st_ff;
      nxt_cnt = (cnt_ff != 20'h00000) ? cnt_ff - 20'h00001 : cnt_ff;
      nxt_idx = idx_ff;
      nxt_word = word_ff;
      nxt_perr = perr_ff;
      nxt_start = 1'b0;
      nxt_stop = 1'b0;
      nxt_valid = 1'b0;
      nxt_err = err_ff;
      unique case (st_ff)
         S_IDLE: if (prev_ff && !line) begin
            nxt_start = 1'b1;
            nxt_cnt = half - 20'h00001;
            nxt_word = 8'h00;
            nxt_idx = 3'h0;
            nxt_perr = 1'b0;
            nxt_st = S_START;
         end
         S_START: if (cnt_ff == 20'h00000) begin
            // a glitch that is gone by mid-bit is not a character
            nxt_st = line ? S_IDLE : S_DATA;
            nxt_cnt = bit_cycles - 20'h00001;
         end
         S_DATA: if (cnt_ff == 20'h00000) begin
            nxt_word[idx_ff] = line;
            nxt_cnt = bit_cycles - 20'h00001;
            nxt_idx = idx_ff + 3'h1;
            if (idx_ff == last_idx) begin
               nxt_st = (parity == PAR_NONE) ? S_STOP : S_PARITY;
            end
         end
         S_PARITY: if (cnt_ff == 20'h00000) begin
            nxt_perr = (^word_ff ^ line) != (parity == PAR_ODD);
            nxt_cnt = bit_cycles - 20'h00001;
            nxt_st = S_STOP;
         end
         S_STOP: if (cnt_ff == 20'h00000) begin
            nxt_stop = 1'b1;
            nxt_valid = 1'b1;
            nxt_err = perr_ff | ~line;
            if (!line || stop_bits == STOP_1) begin
               nxt_st = S_IDLE;
            end else begin
               // stay busy until the extra stop time has passed
               nxt_cnt = (stop_bits == STOP_1P5) ? bit_cycles - 20'h00001 : bit_cycles + half - 20'h00001;
               nxt_st = S_TAIL;
            end
         end
         S_TAIL: if (cnt_ff == 20'h00000) begin
            nxt_st = S_IDLE;
         end
         default: nxt_st = S_IDLE;
      endcase
      nxt_fault = (nxt_st == S_IDLE) && (line != `LINE_IDLE_LEVEL);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= S_IDLE;
         cnt_ff <= 20'h00000;
         idx_ff <= 3'h0;
         word_ff <= 8'h00;
         perr_ff <= 1'b0;
         prev_ff <= `LINE_IDLE_LEVEL;
         start_ff <= 1'b0;
         stop_ff <= 1'b0;
         valid_ff <= 1'b0;
         err_ff <= 1'b0;
         fault_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         idx_ff <= nxt_idx;
         word_ff <= nxt_word;
         perr_ff <= nxt_perr;
         prev_ff <= line;
         start_ff <= nxt_start;
         stop_ff <= nxt_stop;
         valid_ff <= nxt_valid;
         err_ff <= nxt_err;
         fault_ff <= nxt_fault;
      end
   end

   assign res.start_p = start_ff;
   assign res.stop_p = stop_ff;
   assign res.word_valid = valid_ff;
   assign res.word = word_ff;
   assign res.err = err_ff;
   assign res.busy = (st_ff != S_IDLE);
   assign res.idle_fault = fault_ff;
endmodule

// ---- core/line_sync.sv ----
/*
 three-flop synchroniser for a pin; output moves once stages two and three agree.
 assumes the pin idles high and is asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "serial_trig_consts.svh"
module line_sync (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic [2:0] st_ff;
   logic [2:0] nxt_st;
   logic lvl_ff;
   logic nxt_lvl;

   always_comb begin
      nxt_st = {st_ff[1:0], pin};
      nxt_lvl = (st_ff[1] == st_ff[2]) ? st_ff[2] : lvl_ff;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= {3{`LINE_IDLE_LEVEL}};
         lvl_ff <= `LINE_IDLE_LEVEL;
      end else begin
         st_ff <= nxt_st;
         lvl_ff <= nxt_lvl;
      end
   end

   assign level = lvl_ff;
endmodule

// ---- core/serial_trig_consts.svh ----
/*
 offsets, field positions, reset values and timing counts of the serial trigger decoder.
 assumes inclusion by the modules of the decoder; definitions only.
*/
// Contract
// - trigger examines either the transmit or the receive line, chosen by a source setting; stop mode ignores the setting and always uses the receive line
// - start mode pulses the trigger on the start bit of a character on the chosen line
// - stop mode pulses the trigger when a stop bit is detected on the receive line
// - one, one-and-a-half or two stop bits frame each character
// - data mode compares each word with a byte using equal, less or greater
// - character width is five to eight bits and data compare uses that width
// - parity is odd, even or none; when on, received parity is checked
// - bit period comes from a standard baud list or a custom programmed period
// - each receive word reports an error on parity mismatch or other decode failure
// - each transmit word reports an error on parity mismatch or other decode failure
// - a fault shows while a line rests at the level opposite to idle
// - status tells a frame in progress apart from an idle line
`ifndef SERIAL_TRIG_CONSTS_SVH
`define SERIAL_TRIG_CONSTS_SVH

`define CLK_HZ 25000000
`define BAUD_0 600
`define BAUD_1 1200
`define BAUD_2 2400
`define BAUD_3 4800
`define BAUD_4 9600
`define BAUD_5 19200
`define BAUD_6 38400
`define BAUD_7 57600
`define BAUD_8 115200
`define MIN_BIT_CYCLES 20'h00004

`define OFS_CTRL 8'h00
`define OFS_VALUE 8'h04
`define OFS_CUSTOM 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RXWORD 8'h10
`define OFS_TXWORD 8'h14
`define OFS_INT_STAT 8'h18
`define OFS_INT_MASK 8'h1c

`define CTRL_MODE_LSB 0
`define CTRL_CMP_LSB 2
`define CTRL_SRC_BIT 4
`define CTRL_PAR_LSB 5
`define CTRL_STOP_LSB 7
`define CTRL_LEN_LSB 9
`define CTRL_BAUD_LSB 11
`define CTRL_WIDTH 15
`define CTRL_RESET 15'h2000
`define VALUE_RESET 8'h00
`define CUSTOM_RESET 20'h00a2c
`define INT_WIDTH 4
`define WORD_ERR_BIT 8

`define EV_TRIG 0
`define EV_RX_ERR 1
`define EV_TX_ERR 2
`define EV_IDLE_FAULT 3

`define LINE_RX 0
`define LINE_TX 1
`define LINE_IDLE_LEVEL 1'b1
`define MIN_DATA_BITS 3'h4

`endif

// ---- core/serial_trig_pkg.sv ----
/*
 types shared by the serial trigger decoder modules.
 assumes the constants header is available on the include path.
*/
package serial_trig_pkg;
   typedef enum logic [1:0] {TRIG_START, TRIG_STOP, TRIG_DATA} trig_mode_t;
   typedef enum logic [1:0] {CMP_EQ, CMP_LT, CMP_GT} cmp_t;
   typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_t;
   typedef enum logic [1:0] {STOP_1, STOP_1P5, STOP_2} stop_t;
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PARITY, S_STOP, S_TAIL} dec_state_t;
endpackage

// ---- core/serial_trig_top.sv ----
/*
 serial trigger decoder top: AHB-Lite registers, two line decoders, trigger and interrupt.
 assumes a single AHB-Lite master on ref_clk and asynchronous rx/tx pins idling high.
*/
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "serial_trig_consts.svh"
module serial_trig_top
   import serial_trig_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic rx_pin,
   input wire logic transmit_line_source,
   output logic trig_out,
   output logic irq
);
   import serial_trig_pkg::*;

   logic [1:0] pins;
   logic [1:0] lvl;
   logic [1:0] start_p, stop_p, valid_p, err_w, busy_w, fault_w;
   logic [7:0] word_w [2];
   line_decode_if dec_if [2] ();

   logic [`CTRL_WIDTH-1:0] ctrl_ff, nxt_ctrl;
   logic [7:0] value_ff, nxt_value;
   logic [19:0] custom_ff, nxt_custom;
   logic [`INT_WIDTH-1:0] ist_ff, nxt_ist, imask_ff, nxt_imask;
   logic [8:0] rxw_ff, nxt_rxw, txw_ff, nxt_txw;
   logic [1:0] fault_q_ff;
   logic trig_ff, nxt_trig, irq_ff, nxt_irq;
   logic wr_pend_ff, nxt_wr_pend;
   logic [7:0] wr_addr_ff, nxt_wr_addr;
   logic [31:0] rdata_ff, nxt_rdata;

   trig_mode_t mode;
   cmp_t cmp;
   logic src;
   logic [19:0] bit_cycles;
   logic [7:0] sel_word;
   logic hit;
   logic [`INT_WIDTH-1:0] ev;
   logic [`INT_WIDTH-1:0] w1c;
   logic addr_ok;

   function automatic logic [19:0] baud_cycles(input logic [3:0] sel, input logic [19:0] custom);
      logic [19:0] c;
      c = custom;
      unique case (sel)
         4'h0: c = 20'(`CLK_HZ / `BAUD_0);
         4'h1: c = 20'(`CLK_HZ / `BAUD_1);
         4'h2: c = 20'(`CLK_HZ / `BAUD_2);
         4'h3: c = 20'(`CLK_HZ / `BAUD_3);
         4'h4: c = 20'(`CLK_HZ / `BAUD_4);
         4'h5: c = 20'(`CLK_HZ / `BAUD_5);
         4'h6: c = 20'(`CLK_HZ / `BAUD_6);
         4'h7: c = 20'(`CLK_HZ / `BAUD_7);
         4'h8: c = 20'(`CLK_HZ / `BAUD_8);
         default: c = (custom < `MIN_BIT_CYCLES) ? `MIN_BIT_CYCLES : custom;
      endcase
      return c;
   endfunction

   function automatic logic compare(input cmp_t kind, input logic [7:0] a, input logic [7:0] b);
      logic r;
      r = 1'b0;
      unique case (kind)
         CMP_EQ: r = (a == b);
         CMP_LT: r = (a < b);
         CMP_GT: r = (a > b);
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   assign pins = {transmit_line_source, rx_pin};
   assign mode = trig_mode_t'(ctrl_ff[`CTRL_MODE_LSB +: 2]);
   assign cmp = cmp_t'(ctrl_ff[`CTRL_CMP_LSB +: 2]);
   assign src = ctrl_ff[`CTRL_SRC_BIT];
   assign bit_cycles = baud_cycles(ctrl_ff[`CTRL_BAUD_LSB +: 4], custom_ff);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_line
         line_sync u_sync (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .pin(pins[g]),
            .level(lvl[g])
         );
         line_decoder u_dec (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .line(lvl[g]),
            .bit_cycles(bit_cycles),
            .len_sel(ctrl_ff[`CTRL_LEN_LSB +: 2]),
            .parity(parity_t'(ctrl_ff[`CTRL_PAR_LSB +: 2])),
            .stop_bits(stop_t'(ctrl_ff[`CTRL_STOP_LSB +: 2])),
            .res(dec_if[g])
         );
         assign start_p[g] = dec_if[g].start_p;
         assign stop_p[g] = dec_if[g].stop_p;
         assign valid_p[g] = dec_if[g].word_valid;
         assign err_w[g] = dec_if[g].err;
         assign busy_w[g] = dec_if[g].busy;
         assign fault_w[g] = dec_if[g].idle_fault;
         assign word_w[g] = dec_if[g].word;
      end
   endgenerate

   // trigger
   always_comb begin
      sel_word = src ? word_w[`LINE_TX] : word_w[`LINE_RX];
      hit = 1'b0;
      unique case (mode)
         TRIG_START: hit = src ? start_p[`LINE_TX] : start_p[`LINE_RX];
         TRIG_STOP: hit = stop_p[`LINE_RX];
         TRIG_DATA: hit = (src ? valid_p[`LINE_TX] : valid_p[`LINE_RX]) && compare(cmp, sel_word, value_ff);
         default: hit = 1'b0;
      endcase
      nxt_trig = hit;
      nxt_rxw = valid_p[`LINE_RX] ? {err_w[`LINE_RX], word_w[`LINE_RX]} : rxw_ff;
      nxt_txw = valid_p[`LINE_TX] ? {err_w[`LINE_TX], word_w[`LINE_TX]} : txw_ff;
      ev = '0;
      ev[`EV_TRIG] = hit;
      ev[`EV_RX_ERR] = valid_p[`LINE_RX] & err_w[`LINE_RX];
      ev[`EV_TX_ERR] = valid_p[`LINE_TX] & err_w[`LINE_TX];
      ev[`EV_IDLE_FAULT] = |(fault_w & ~fault_q_ff);
   end

   // AHB-Lite slave: zero wait states, reads decoded in the address phase
   always_comb begin
      addr_ok = hsel && hready && htrans[1];
      nxt_wr_pend = addr_ok && hwrite;
      nxt_wr_addr = addr_ok ? haddr[7:0] : wr_addr_ff;
      nxt_ctrl = ctrl_ff;
      nxt_value = value_ff;
      nxt_custom = custom_ff;
      nxt_imask = imask_ff;
      w1c = '0;
      if (wr_pend_ff) begin
         unique case (wr_addr_ff)
            `OFS_CTRL: nxt_ctrl = hwdata[`CTRL_WIDTH-1:0];
            `OFS_VALUE: nxt_value = hwdata[7:0];
            `OFS_CUSTOM: nxt_custom = hwdata[19:0];
            `OFS_INT_STAT: w1c = hwdata[`INT_WIDTH-1:0];
            `OFS_INT_MASK: nxt_imask = hwdata[`INT_WIDTH-1:0];
            default: nxt_ctrl = ctrl_ff;
         endcase
      end
      // an event in the clearing cycle survives the clear
      nxt_ist = (ist_ff & ~w1c) | ev;
      nxt_irq = |(nxt_ist & nxt_imask);
      nxt_rdata = 32'h00000000;
      if (addr_ok && !hwrite) begin
         unique case (haddr[7:0])
            `OFS_CTRL: nxt_rdata = {17'h00000, ctrl_ff};
            `OFS_VALUE: nxt_rdata = {24'h000000, value_ff};
            `OFS_CUSTOM: nxt_rdata = {12'h000, custom_ff};
            `OFS_STATUS: nxt_rdata = {28'h0000000, fault_w, busy_w};
            `OFS_RXWORD: nxt_rdata = {23'h000000, rxw_ff};
            `OFS_TXWORD: nxt_rdata = {23'h000000, txw_ff};
            `OFS_INT_STAT: nxt_rdata = {28'h0000000, ist_ff};
            `OFS_INT_MASK: nxt_rdata = {28'h0000000, imask_ff};
            default: nxt_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= `CTRL_RESET;
         value_ff <= `VALUE_RESET;
         custom_ff <= `CUSTOM_RESET;
         ist_ff <= '0;
         imask_ff <= '0;
         rxw_ff <= 9'h000;
         txw_ff <= 9'h000;
         fault_q_ff <= 2'h0;
         trig_ff <= 1'b0;
         irq_ff <= 1'b0;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         rdata_ff <= 32'h00000000;
      end else begin
         ctrl_ff <= nxt_ctrl;
         value_ff <= nxt_value;
         custom_ff <= nxt_custom;
         ist_ff <= nxt_ist;
         imask_ff <= nxt_imask;
         rxw_ff <= nxt_rxw;
         txw_ff <= nxt_txw;
         fault_q_ff <= fault_w;
         trig_ff <= nxt_trig;
         irq_ff <= nxt_irq;
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
         rdata_ff <= nxt_rdata;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;
   assign trig_out = trig_ff;
   assign irq = irq_ff;
endmodule

// ---- verif/async_serial_trigger_decoder_tb_top.sv ----
/*
 self-checking bench for serial_trig_top: bus tasks, frames from the line model, trigger counting.
 assumes the custom bit period selection (9) with a short period of 16 cycles, plus one frame at the fastest
 listed rate.
*/
`timescale 1ns/1ps
module async_serial_trigger_decoder_tb_top;
   import serial_trig_pkg::*;
   localparam int BC = 16;
   // bit period of the fastest listed rate, in whole clock cycles
   localparam int BC8 = 25000000 / 115200;
   logic ref_clk, rst_n, hsel, hwrite;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] w;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, trig_out, irq, rx_pin, tx_pin;
   int miscompares = 0;
   int checked = 0;
   int trigs = 0;
   int t0, c, l, i;
   serial_trig_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .rx_pin(rx_pin), .transmit_line_source(tx_pin), .trig_out(trig_out),
      .irq(irq));
   serial_line_model partner (.ref_clk(ref_clk), .rx_pin(rx_pin), .tx_pin(tx_pin));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (trig_out === 1'b1) trigs <= trigs + 1;
   task end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      q = hrdata;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   function automatic logic [31:0] ctrl(int mode, int cmp, int src, int par, int stop, int len);
      return 32'(mode | (cmp << 2) | (src << 4) | (par << 5) | (stop << 7) | (len << 9) | (9 << 11));
   endfunction
   task frame(input logic sel, input logic [7:0] d, input int nb, input int par, input logic bad_p, input int stop_h);
      t0 = trigs;
      partner.send(sel, d, nb, par, bad_p, stop_h, 1'b0, BC);
      repeat (8) @(posedge ref_clk);
   endtask
   initial begin
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      rst_n = 1'b0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h2000);
      rd(8'h08, 32'ha2c);
      rd(8'h0c, 32'h0);
      rd(8'h1c, 32'h0);
      ahb(1'b1, 8'h20, 32'hffff);
      rd(8'h20, 32'h0);
      ahb(1'b1, 8'h08, BC);
      $display("test reset values done");
      ahb(1'b1, 8'h00, ctrl(0, 0, 1, 0, 0, 3));
      rd(8'h00, ctrl(0, 0, 1, 0, 0, 3));
      frame(1'b0, 8'h55, 8, 0, 1'b0, 2);
      check(trigs - t0, 0);
      frame(1'b1, 8'h55, 8, 0, 1'b0, 2);
      check(trigs - t0, 1);
      ahb(1'b1, 8'h00, ctrl(0, 0, 0, 0, 0, 3));
      frame(1'b0, 8'h55, 8, 0, 1'b0, 2);
      check(trigs - t0, 1);
      $display("test source and start done");
      for (i = 0; i < 3; i++) begin
         ahb(1'b1, 8'h00, ctrl(1, 0, 1, 0, i, 3));
         frame(1'b1, 8'ha3, 8, 0, 1'b0, i + 2);
         check(trigs - t0, 0);
         frame(1'b0, 8'ha3, 8, 0, 1'b0, i + 2);
         check(trigs - t0, 1);
         rd(8'h10, 32'ha3);
      end
      fork
         partner.send(1'b0, 8'h0f, 8, 0, 1'b0, 2, 1'b0, BC);
         begin
            repeat (BC * 4) @(posedge ref_clk);
            rd(8'h0c, 32'h1);
         end
      join
      rd(8'h0c, 32'h0);
      $display("test stop mode done");
      ahb(1'b1, 8'h04, 32'h10);
      for (l = 0; l < 4; l += 3) for (c = 0; c < 3; c++) for (w = 8'h0f; w < 8'h12; w++) begin
         ahb(1'b1, 8'h00, ctrl(2, c, 0, 0, 0, l));
         // at five bits the set upper bits lie beyond the width and are never sent by the line model
         frame(1'b0, w | ((l == 3) ? 8'h00 : 8'he0), l + 5, 0, 1'b0, 2);
         check(trigs - t0, (c == 0) ? (w == 8'h10) : (c == 1) ? (w < 8'h10) : (w > 8'h10));
         rd(8'h10, {24'h0, w});
      end
      // the period must come from the rate table here, not from the custom register
      ahb(1'b1, 8'h00, ctrl(2, 2, 0, 0, 0, 3) & ~32'h800);
      t0 = trigs;
      partner.send(1'b0, 8'ha5, 8, 0, 1'b0, 2, 1'b0, BC8);
      repeat (8) @(posedge ref_clk);
      check(trigs - t0, 1);
      rd(8'h10, 32'ha5);
      $display("test data compare done");
      for (i = 1; i < 3; i++) begin
         ahb(1'b1, 8'h00, ctrl(0, 0, 0, i, 0, 3));
         ahb(1'b1, 8'h18, 32'hf);
         frame(1'b0, 8'h5a, 8, i, 1'b0, 2);
         rd(8'h10, 32'h5a);
         frame(1'b0, 8'h5b, 8, i, 1'b1, 2);
         rd(8'h10, 32'h15b);
         rd(8'h18, 32'h3);
      end
      ahb(1'b1, 8'h1c, 32'h2);
      repeat (2) @(posedge ref_clk);
      check({31'h0, irq}, 32'h1);
      ahb(1'b1, 8'h1c, 32'h0);
      repeat (2) @(posedge ref_clk);
      check({31'h0, irq}, 32'h0);
      ahb(1'b1, 8'h1c, 32'h2);
      ahb(1'b1, 8'h18, 32'hf);
      repeat (2) @(posedge ref_clk);
      check({31'h0, irq}, 32'h0);
      ahb(1'b1, 8'h00, ctrl(0, 0, 1, 1, 0, 3));
      frame(1'b1, 8'h5a, 8, 1, 1'b1, 2);
      rd(8'h14, 32'h15a);
      rd(8'h18, 32'h5);
      $display("test parity errors done");
      ahb(1'b1, 8'h00, ctrl(0, 0, 0, 0, 0, 3));
      ahb(1'b1, 8'h18, 32'hf);
      partner.send(1'b0, 8'h3c, 8, 0, 1'b0, 2, 1'b1, BC);
      repeat (BC * 2) @(posedge ref_clk);
      rd(8'h0c, 32'h4);
      rd(8'h10, 32'h13c);
      rd(8'h18, 32'hb);
      partner.rest(1'b0, BC);
      rd(8'h0c, 32'h0);
      $display("test framing fault done");
      end_of_test;
   end
   initial begin
      #(40 * 60000);
      miscompares++;
      end_of_test;
   end
endmodule

// ---- verif/serial_line_model.sv ----
/*
 model of the monitored device's receive and transmit lines.
 assumes bit timing counted in ref_clk cycles; both lines are push-pull and idle high.
*/
`timescale 1ns/1ps
module serial_line_model (
   input wire logic ref_clk,
   output logic rx_pin,
   output logic tx_pin
);
   initial begin
      rx_pin = 1'b1;
      tx_pin = 1'b1;
   end
   task bit_out(input logic sel, input logic v, input int n);
      @(posedge ref_clk);
      if (sel) tx_pin <= v;
      else rx_pin <= v;
      repeat (n - 1) @(posedge ref_clk);
   endtask
   // stop_h is in half bits; a bad stop leaves the line low until rest is called
   task send(input logic sel, input logic [7:0] d, input int nb, input int par, input logic bad_p,
             input int stop_h, input logic bad_s, input int bc);
      logic p;
      int i;
      p = ^(d & ((8'h1 << nb) - 8'h1)) ^ (par == 1) ^ bad_p;
      bit_out(sel, 1'b0, bc);
      for (i = 0; i < nb; i++) bit_out(sel, d[i], bc);
      if (par != 0) bit_out(sel, p, bc);
      bit_out(sel, !bad_s, stop_h * bc / 2);
      if (!bad_s) bit_out(sel, 1'b1, 2 * bc);
   endtask
   task rest(input logic sel, input int bc);
      bit_out(sel, 1'b1, 2 * bc);
   endtask
endmodule

// ---- verif/serial_trig_top_properties.sv ----
/*
 concurrent checks on the ports of serial_trig_top.
 assumes a single ref_clk domain with asynchronous rst_n and a zero-wait slave.
*/
`timescale 1ns/1ps
module serial_trig_props (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic trig_out,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd(logic [7:0] ofs);
      hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ofs;
   endsequence
   // mask cleared: address phase, then zero data one cycle later
   sequence s_mask_off;
      hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h1c ##1 hwdata == 32'h0;
   endsequence
   AST_HREADY: assert property (hreadyout == 1'b1)
      else $error("slave inserted a wait state");
   AST_OKAY: assert property (hresp == 1'b0)
      else $error("slave gave a non-okay response");
   AST_TRIG_ONE: assert property ($rose(trig_out) |=> $fell(trig_out))
      else $error("trigger pulse longer than one cycle");
   AST_IDLE_ZERO: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
      else $error("read data not cleared after a non-read cycle");
   AST_UNMAPPED: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:0] >= 8'h20 |=> hrdata == 32'h0)
      else $error("unmapped offset returned data");
   AST_STATUS_HI: assert property (s_rd(8'h0c) |=> hrdata[31:4] == 28'h0)
      else $error("status upper bits not zero");
   AST_RXWORD_HI: assert property (s_rd(8'h10) |=> hrdata[31:9] == 23'h0)
      else $error("receive word upper bits not zero");
   AST_TXWORD_HI: assert property (s_rd(8'h14) |=> hrdata[31:9] == 23'h0)
      else $error("transmit word upper bits not zero");
   AST_CTRL_HI: assert property (s_rd(8'h00) |=> hrdata[31:15] == 17'h0)
      else $error("control upper bits not zero");
   AST_IRQ_MASK: assert property (s_mask_off |-> ##2 !irq)
      else $error("interrupt stayed high with mask cleared");
endmodule

bind serial_trig_top serial_trig_props props_i (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .hresp(hresp), .trig_out(trig_out), .irq(irq));
